// >>> general_purpose_io_port_tb.sv
`timescale 1ns/10ps
`include "gpp_map.vh"

module general_purpose_io_port_tb;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, pready, pslverr, er, boot, stop_n = 1'h1;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic [12:0] pa_in, pa_out, pa_oe, pa_alt_in;
  logic [12:0] ao = 13'h0, ae = 13'h0, xa = 13'h0, va = 13'h0;
  logic [4:0] pb_in, pb_out, pb_oe, pb_alt_in, bo = 5'h0, be = 5'h0;
  int n_fail = 0;
  int n_checks = 0;

  gpp_top u_gpp_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .pa_in, .pa_out, .pa_oe,
    .pa_alt_out(ao), .pa_alt_oe(ae), .pa_alt_in, .pb_in, .pb_out, .pb_oe,
    .pb_alt_out(bo), .pb_alt_oe(be), .pb_alt_in,
    .wakeup_unit_stop_req_n(stop_n), .boot_mode_select(boot));
  gpp_pins #(.W(13)) u_gpp_pins_a (.drv(pa_out), .oe(pa_oe), .ext_en(xa),
    .ext_val(va), .lvl(pa_in));
  gpp_pins #(.W(5)) u_gpp_pins_b (.drv(pb_out), .oe(pb_oe),
    .ext_en(5'h0), .ext_val(5'h0), .lvl(pb_in));

  initial forever #5 pclk = ~pclk;

  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task chk(string n, logic [31:0] s, logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask

  // one apb transfer; waits for ready, then releases
  task apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // no cycle count is assumed; the watchdog ends a missing answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task wr(logic [11:0] a, logic [31:0] d);
    apb(1'h1, a, d);
  endtask

  task rdc(string n, logic [11:0] a, logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(n, rd, e);
  endtask

  // pins follow one cycle after the write lands
  task settle;
    repeat (2) @(posedge pclk);
    #1;
  endtask

  task do_reset;
    @(posedge pclk);
    presetn <= 1'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
  endtask

  task t_reset;
    settle;
    chk("a_oe", 32'(pa_oe), 32'h0);
    chk("b_oe", 32'(pb_oe), 32'h0);
    rdc("stat", `GPP_OFS_STAT, 32'h7);
    $display("test reset done");
  endtask

  task t_regs;
    logic [11:0] ra [6] = '{`GPP_OFS_A_CFG, `GPP_OFS_A_DIR, `GPP_OFS_A_ODS,
      `GPP_OFS_B_CFG, `GPP_OFS_B_DIR, `GPP_OFS_B_ODS};
    for (int i = 0; i < 6; i++) begin
      rdc("rst", ra[i], 32'h0);
      wr(ra[i], 32'hffff_ffff);
      rdc("ones", ra[i], i < 3 ? 32'h1fff : 32'h1f);
      wr(ra[i], 32'h0);
    end
    $display("test regs done");
  endtask

  task t_io;
    xa <= 13'h1fff;
    va <= 13'h1234;
    wr(`GPP_OFS_A_DAT, 32'h0a5a);
    settle;
    chk("oe_in", 32'(pa_oe), 32'h0);
    rdc("pin", `GPP_OFS_A_DAT, 32'h1234);
    va <= 13'h0ccc;
    settle;
    rdc("pin2", `GPP_OFS_A_DAT, 32'h0ccc);
    xa <= 13'h0;
    wr(`GPP_OFS_A_DIR, 32'h1fff);
    wr(`GPP_OFS_B_DIR, 32'h1f);
    wr(`GPP_OFS_B_DAT, 32'h15);
    settle;
    chk("a_out", 32'(pa_out), 32'h0a5a);
    chk("a_oe", 32'(pa_oe), 32'h1fff);
    chk("b_out", 32'(pb_out), 32'h15);
    chk("b_oe", 32'(pb_oe), 32'h1f);
    rdc("b_rb", `GPP_OFS_B_DAT, 32'h15);
    $display("test io done");
  endtask

  // far side holds lines 0 and 1 low while open drain
  task t_od;
    xa <= 13'h0003;
    va <= 13'h0;
    wr(`GPP_OFS_A_ODS, 32'h1fff);
    settle;
    chk("od_oe", 32'(pa_oe), 32'h15a5);
    chk("od_out", 32'(pa_out & pa_oe), 32'h0);
    chk("od_pin", 32'(pa_in), 32'h0a58);
    rdc("od_rb", `GPP_OFS_A_DAT, 32'h0a5a);
    xa <= 13'h0;
    wr(`GPP_OFS_A_ODS, 32'h0);
    $display("test open drain done");
  endtask

  task t_alt;
    ao <= 13'h0005;
    ae <= 13'h0007;
    wr(`GPP_OFS_A_CFG, 32'h0087);
    settle;
    chk("alt_oe", 32'(pa_oe), 32'h1fff);
    chk("alt_out", 32'(pa_out), 32'h0add);
    @(posedge pclk);
    ae <= 13'h0006;
    stop_n <= 1'h0;
    settle;
    chk("alt_oe2", 32'(pa_oe), 32'h1ffe);
    chk("stop", 32'(pa_out & pa_oe), 32'h0a5c);
    rdc("stat_stop", `GPP_OFS_STAT, 32'h3);
    stop_n <= 1'h1;
    bo <= 5'h02;
    be <= 5'h03;
    wr(`GPP_OFS_B_CFG, 32'h3);
    settle;
    chk("b_alt_out", 32'(pb_out), 32'h16);
    chk("b_alt_in", 32'(pb_alt_in), 32'h16);
    rdc("b_alt_rb", `GPP_OFS_B_DAT, 32'h16);
    $display("test alt done");
  endtask

  task t_err;
    wr(`GPP_OFS_STAT, 32'h0);
    chk("stat_wr", 32'(er), 32'h1);
    wr(`GPP_OFS_A_LAT, 32'h0);
    chk("lat_wr", 32'(er), 32'h1);
    wr(12'h100, 32'h0);
    chk("hole_wr", 32'(er), 32'h1);
    apb(1'h0, 12'h104, 32'h0);
    chk("hole_rd", 32'(er), 32'h1);
    rdc("cfg", `GPP_OFS_A_CFG, 32'h0087);
    $display("test err done");
  endtask

  // second reset with the strap line held low
  task t_boot;
    xa <= 13'h0040;
    va <= 13'h0;
    do_reset;
    settle;
    chk("boot", 32'(boot), 32'h0);
    chk("oe_rst", 32'(pa_oe), 32'h0);
    rdc("stat2", `GPP_OFS_STAT, 32'h6);
    rdc("cfg_rst", `GPP_OFS_A_CFG, 32'h0);
    $display("test boot done");
  endtask

  // whole run is well under 2000 cycles; this cuts a hang
  initial begin
    #200000;
    n_fail++;
    report_and_stop;
  end

  initial begin
    do_reset;
    t_reset;
    t_regs;
    t_io;
    t_od;
    t_alt;
    t_err;
    t_boot;
    report_and_stop;
  end
endmodule

// >>> gpp_bank.v
`timescale 1ns/10ps
`include "gpp_map.vh"

module gpp_bank #(
  parameter W = 13
) (
  input wire pclk,
  input wire presetn,
  input wire [W-1:0] cfg,
  input wire [W-1:0] dir,
  input wire [W-1:0] ods,
  input wire [W-1:0] dat,
  input wire [W-1:0] alt_out,
  input wire [W-1:0] alt_oe,
  input wire [W-1:0] pin_in,
  output reg [W-1:0] pin_out,
  output reg [W-1:0] pin_oe,
  output reg [W-1:0] alt_in,
  output reg [W-1:0] port_rd
);

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_line
      // cfg set hands the line to its peripheral, else gp by dir
      wire drv_gp = ~cfg[i] & dir[i];
      wire drv = drv_gp | (cfg[i] & alt_oe[i]);
      wire val = cfg[i] ? alt_out[i] : dat[i];

      // open drain: a one releases the pin, only a zero is driven
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pin_out[i] <= `GPP_DAT_RST;
          pin_oe[i] <= 1'b0;
          alt_in[i] <= 1'b0;
          port_rd[i] <= 1'b0;
        end else begin
          pin_out[i] <= ods[i] ? 1'b0 : val;
          pin_oe[i] <= drv & (~ods[i] | ~val);
          alt_in[i] <= pin_in[i];
          // driven lines read the driver input, others the pin
          port_rd[i] <= drv ? val : pin_in[i];
        end
      end
    end
  endgenerate

endmodule

// >>> gpp_chk_assertions.sv
`timescale 1ns/10ps
`include "gpp_map.vh"

module gpp_chk #(
  parameter WA = 13,
  parameter WB = 5
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`GPP_AW-1:0] paddr,
  input wire pready,
  input wire pslverr,
  input wire [WA-1:0] pa_in,
  input wire [WA-1:0] pa_oe,
  input wire [WA-1:0] pa_alt_in,
  input wire [WB-1:0] pb_oe,
  input wire boot_mode_select
);
  // single domain, so clock and reset are stated once
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // apb answers after exactly one wait state, for one cycle
  chk_one_wait: assert property (
    psel && penable && !pready |=> pready) else $error("late answer");
  chk_ready_pulse: assert property (
    pready |=> !pready) else $error("ready too long");
  chk_err_ready: assert property (
    pslverr |-> pready) else $error("error without ready");
  // status word is read-only
  chk_stat_ro: assert property (
    psel && penable && pwrite && !pready && paddr == `GPP_OFS_STAT
    |=> pslverr) else $error("status write taken");
  // nothing driven just after reset
  chk_reset_idle: assert property (
    $rose(presetn) |-> ##2 (pa_oe == '0 && pb_oe == '0))
    else $error("pin driven after reset");
  // strap taken at first edge after release, then held
  chk_boot_take: assert property (
    $rose(presetn) |=> boot_mode_select == $past(pa_in[`GPP_BOOT_LINE]))
    else $error("boot strap wrong");
  chk_boot_hold: assert property (
    !$rose(presetn) |=> $stable(boot_mode_select))
    else $error("boot strap moved");
  // peripherals see the pins one cycle late
  chk_alt_copy: assert property (
    presetn |=> pa_alt_in == $past(pa_in)) else $error("alt input wrong");
endmodule

bind gpp_top gpp_chk #(.WA(WA), .WB(WB)) u_gpp_chk (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pready, .pslverr, .pa_in, .pa_oe,
  .pa_alt_in, .pb_oe, .boot_mode_select);

// >>> gpp_map.vh
`ifndef GPP_MAP_VH
`define GPP_MAP_VH

// line counts of the two port instances
`define GPP_A_LINES 13
`define GPP_B_LINES 5

// apb byte addresses, one aligned word per register
`define GPP_AW 12
`define GPP_OFS_A_CFG 12'h000
`define GPP_OFS_A_DAT 12'h004
`define GPP_OFS_A_DIR 12'h008
`define GPP_OFS_A_ODS 12'h00c
`define GPP_OFS_A_LAT 12'h010
`define GPP_OFS_B_CFG 12'h020
`define GPP_OFS_B_DAT 12'h024
`define GPP_OFS_B_DIR 12'h028
`define GPP_OFS_B_ODS 12'h02c
`define GPP_OFS_B_LAT 12'h030
`define GPP_OFS_STAT 12'h040

// status register fields
`define GPP_STAT_BOOT 0
`define GPP_STAT_CAPT 1
`define GPP_STAT_STOP 2

// special lines of the first instance
`define GPP_BOOT_LINE 6
`define GPP_STOP_LINE 7

// reset values: cfg 0 = gp line, dir 0 = input, ods 0 = push-pull
`define GPP_CFG_RST 1'b0
`define GPP_DIR_RST 1'b0
`define GPP_ODS_RST 1'b0
`define GPP_DAT_RST 1'b0
`define GPP_WORD_RST 32'h0000_0000

`endif

// >>> gpp_pins.sv
`timescale 1ns/10ps

module gpp_pins #(
  parameter W = 13
) (
  input wire [W-1:0] drv,
  input wire [W-1:0] oe,
  input wire [W-1:0] ext_en,
  input wire [W-1:0] ext_val,
  output logic [W-1:0] lvl
);
  // device wins a fight; a released pin floats to the pull-up
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (oe[i])
        lvl[i] = drv[i];
      else if (ext_en[i])
        lvl[i] = ext_val[i];
      else
        lvl[i] = 1'h1;
    end
  end
endmodule

// >>> gpp_strap.v
`timescale 1ns/10ps
`include "gpp_map.vh"

module gpp_strap (
  input wire pclk,
  input wire presetn,
  input wire pin_level,
  output reg boot_mode_select,
  output reg captured
);

  // the async reset may only load constants, so the strap level is
  // caught by the first clock edge after reset is released
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_mode_select <= 1'b0;
      captured <= 1'b0;
    end else if (!captured) begin
      boot_mode_select <= pin_level;
      captured <= 1'b1;
    end
  end

endmodule

// >>> gpp_top.v
// What this block does
// - first port instance has thirteen independent bidirectional lines
// - second port instance has five lines, same control and readback
// - each port has configuration, data and direction registers
// - configuration, data and direction registers are read/write
// - each line is gp input, gp output or dedicated peripheral line
// - port read allowed any time; input lines return the pin level
// - output lines read back the output driver input, not the pin
// - writes always update data register; pin driven only as gp output
// - each output selectable push-pull or open drain; one releases pin
// - first instance line 6 level captured at reset as boot mode
// - first instance line 7 dedicated: active-low stop request output; here only with cfg bit 7 set, else a gp line
//
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "gpp_map.vh"

module gpp_top #(
  parameter WA = `GPP_A_LINES,
  parameter WB = `GPP_B_LINES
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`GPP_AW-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [WA-1:0] pa_in,
  output wire [WA-1:0] pa_out,
  output wire [WA-1:0] pa_oe,
  input wire [WA-1:0] pa_alt_out,
  input wire [WA-1:0] pa_alt_oe,
  output wire [WA-1:0] pa_alt_in,
  input wire [WB-1:0] pb_in,
  output wire [WB-1:0] pb_out,
  output wire [WB-1:0] pb_oe,
  input wire [WB-1:0] pb_alt_out,
  input wire [WB-1:0] pb_alt_oe,
  output wire [WB-1:0] pb_alt_in,
  input wire wakeup_unit_stop_req_n,
  output wire boot_mode_select
);

  // one-hot apb states: idle/setup, then answer
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_ACK = 2'b10;

  reg [1:0] st_q;
  reg [1:0] st_d;

  // control registers of both instances
  reg [WA-1:0] cfg_a_q;
  reg [WA-1:0] dat_a_q;
  reg [WA-1:0] dir_a_q;
  reg [WA-1:0] ods_a_q;
  reg [WB-1:0] cfg_b_q;
  reg [WB-1:0] dat_b_q;
  reg [WB-1:0] dir_b_q;
  reg [WB-1:0] ods_b_q;

  wire [WA-1:0] rd_a;
  wire [WB-1:0] rd_b;
  wire boot_capt;
  reg stop_req_n_q;

  reg [31:0] rdata_d;
  reg err_d;
  reg wr_ok_q;
  wire [31:0] wmask;
  wire commit;

  // apb data width and the spare bits above each port
  localparam DW = 32;
  localparam ZA = DW - WA;
  localparam ZB = DW - WB;

  // one hit line per mapped word, shared by read and write decode
  wire hit_a_cfg;
  wire hit_a_dat;
  wire hit_a_dir;
  wire hit_a_ods;
  wire hit_a_lat;
  wire hit_b_cfg;
  wire hit_b_dat;
  wire hit_b_dir;
  wire hit_b_ods;
  wire hit_b_lat;
  wire hit_stat;

  // byte strobes turned into a bit mask for partial writes
  assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}},
                  {8{pstrb[1]}}, {8{pstrb[0]}}};

  // a write lands on the edge where the master sees pready high
  assign commit = (st_q == ST_ACK) & psel & penable & pwrite & wr_ok_q;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] wd;
    input [31:0] m;
    begin
      merge = (old & ~m) | (wd & m);
    end
  endfunction

  // word hits from the byte address
  assign hit_a_cfg = (paddr == `GPP_OFS_A_CFG);
  assign hit_a_dat = (paddr == `GPP_OFS_A_DAT);
  assign hit_a_dir = (paddr == `GPP_OFS_A_DIR);
  assign hit_a_ods = (paddr == `GPP_OFS_A_ODS);
  assign hit_a_lat = (paddr == `GPP_OFS_A_LAT);
  assign hit_b_cfg = (paddr == `GPP_OFS_B_CFG);
  assign hit_b_dat = (paddr == `GPP_OFS_B_DAT);
  assign hit_b_dir = (paddr == `GPP_OFS_B_DIR);
  assign hit_b_ods = (paddr == `GPP_OFS_B_ODS);
  assign hit_b_lat = (paddr == `GPP_OFS_B_LAT);
  assign hit_stat = (paddr == `GPP_OFS_STAT);

  // merged word per writable register; the registers take a part-select
  // of it, so the spare upper bits of a write never land anywhere
  wire [DW-1:0] mrg_cfg_a;
  wire [DW-1:0] mrg_dat_a;
  wire [DW-1:0] mrg_dir_a;
  wire [DW-1:0] mrg_ods_a;
  wire [DW-1:0] mrg_cfg_b;
  wire [DW-1:0] mrg_dat_b;
  wire [DW-1:0] mrg_dir_b;
  wire [DW-1:0] mrg_ods_b;
  assign mrg_cfg_a = merge({{ZA{1'b0}}, cfg_a_q}, pwdata, wmask);
  assign mrg_dat_a = merge({{ZA{1'b0}}, dat_a_q}, pwdata, wmask);
  assign mrg_dir_a = merge({{ZA{1'b0}}, dir_a_q}, pwdata, wmask);
  assign mrg_ods_a = merge({{ZA{1'b0}}, ods_a_q}, pwdata, wmask);
  assign mrg_cfg_b = merge({{ZB{1'b0}}, cfg_b_q}, pwdata, wmask);
  assign mrg_dat_b = merge({{ZB{1'b0}}, dat_b_q}, pwdata, wmask);
  assign mrg_dir_b = merge({{ZB{1'b0}}, dir_b_q}, pwdata, wmask);
  assign mrg_ods_b = merge({{ZB{1'b0}}, ods_b_q}, pwdata, wmask);

  // address decode; read-only words refuse writes with an error
  always @* begin
    rdata_d = `GPP_WORD_RST;
    err_d = 1'b0;
    if (hit_a_cfg) begin
      rdata_d[WA-1:0] = cfg_a_q;
    end else if (hit_a_dat) begin
      rdata_d[WA-1:0] = rd_a;
    end else if (hit_a_dir) begin
      rdata_d[WA-1:0] = dir_a_q;
    end else if (hit_a_ods) begin
      rdata_d[WA-1:0] = ods_a_q;
    end else if (hit_a_lat) begin
      rdata_d[WA-1:0] = dat_a_q;
      err_d = pwrite;
    end else if (hit_b_cfg) begin
      rdata_d[WB-1:0] = cfg_b_q;
    end else if (hit_b_dat) begin
      rdata_d[WB-1:0] = rd_b;
    end else if (hit_b_dir) begin
      rdata_d[WB-1:0] = dir_b_q;
    end else if (hit_b_ods) begin
      rdata_d[WB-1:0] = ods_b_q;
    end else if (hit_b_lat) begin
      rdata_d[WB-1:0] = dat_b_q;
      err_d = pwrite;
    end else if (hit_stat) begin
      rdata_d[`GPP_STAT_BOOT] = boot_mode_select;
      rdata_d[`GPP_STAT_CAPT] = boot_capt;
      rdata_d[`GPP_STAT_STOP] = stop_req_n_q;
      err_d = pwrite;
    end else begin
      err_d = 1'b1;
    end
  end

  // apb sequencer: one wait state, answer held for one edge only
  always @* begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (psel & penable) begin
          st_d = ST_ACK;
        end
      end
      ST_ACK: begin
        st_d = ST_IDLE;
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `GPP_WORD_RST;
      wr_ok_q <= 1'b0;
    end else begin
      st_q <= st_d;
      pready <= (st_q == ST_IDLE) & psel & penable;
      if ((st_q == ST_IDLE) & psel & penable) begin
        // read data and error are latched so they leave from a flop
        prdata <= pwrite ? `GPP_WORD_RST : rdata_d;
        pslverr <= err_d;
        wr_ok_q <= ~err_d;
      end else begin
        pslverr <= 1'b0;
        wr_ok_q <= 1'b0;
      end
    end
  end

  // port a configuration; every field resets to an undriven input
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_a_q <= {WA{`GPP_CFG_RST}};
    end else if (commit & hit_a_cfg) begin
      cfg_a_q <= mrg_cfg_a[WA-1:0];
    end
  end

  // port a output data, stored even while a line is an input
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dat_a_q <= {WA{`GPP_DAT_RST}};
    end else if (commit & hit_a_dat) begin
      dat_a_q <= mrg_dat_a[WA-1:0];
    end
  end

  // port a direction, a one makes a gp line an output
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_a_q <= {WA{`GPP_DIR_RST}};
    end else if (commit & hit_a_dir) begin
      dir_a_q <= mrg_dir_a[WA-1:0];
    end
  end

  // port a drive mode, a one selects open drain
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ods_a_q <= {WA{`GPP_ODS_RST}};
    end else if (commit & hit_a_ods) begin
      ods_a_q <= mrg_ods_a[WA-1:0];
    end
  end

  // port b configuration, same meaning as on port a
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_b_q <= {WB{`GPP_CFG_RST}};
    end else if (commit & hit_b_cfg) begin
      cfg_b_q <= mrg_cfg_b[WB-1:0];
    end
  end

  // port b output data
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dat_b_q <= {WB{`GPP_DAT_RST}};
    end else if (commit & hit_b_dat) begin
      dat_b_q <= mrg_dat_b[WB-1:0];
    end
  end

  // port b direction
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_b_q <= {WB{`GPP_DIR_RST}};
    end else if (commit & hit_b_dir) begin
      dir_b_q <= mrg_dir_b[WB-1:0];
    end
  end

  // port b drive mode
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ods_b_q <= {WB{`GPP_ODS_RST}};
    end else if (commit & hit_b_ods) begin
      ods_b_q <= mrg_ods_b[WB-1:0];
    end
  end

  // stop request copy for the status word, idle high
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_req_n_q <= 1'b1;
    end else begin
      stop_req_n_q <= wakeup_unit_stop_req_n;
    end
  end

  // line 7 peripheral is the wake-up unit's active-low stop request;
  // it only reaches the pin once software selects the peripheral
  wire [WA-1:0] a_alt_out;
  wire [WA-1:0] a_alt_oe;
  assign a_alt_out = (pa_alt_out & ~({{(WA-1){1'b0}}, 1'b1}
                     << `GPP_STOP_LINE)) |
                     ({{(WA-1){1'b0}}, wakeup_unit_stop_req_n}
                     << `GPP_STOP_LINE);
  assign a_alt_oe = pa_alt_oe |
                    ({{(WA-1){1'b0}}, 1'b1} << `GPP_STOP_LINE);

  gpp_bank #(
    .W(WA)
  ) u_bank_a (
    .pclk(pclk),
    .presetn(presetn),
    .cfg(cfg_a_q),
    .dir(dir_a_q),
    .ods(ods_a_q),
    .dat(dat_a_q),
    .alt_out(a_alt_out),
    .alt_oe(a_alt_oe),
    .pin_in(pa_in),
    .pin_out(pa_out),
    .pin_oe(pa_oe),
    .alt_in(pa_alt_in),
    .port_rd(rd_a)
  );

  gpp_bank #(
    .W(WB)
  ) u_bank_b (
    .pclk(pclk),
    .presetn(presetn),
    .cfg(cfg_b_q),
    .dir(dir_b_q),
    .ods(ods_b_q),
    .dat(dat_b_q),
    .alt_out(pb_alt_out),
    .alt_oe(pb_alt_oe),
    .pin_in(pb_in),
    .pin_out(pb_out),
    .pin_oe(pb_oe),
    .alt_in(pb_alt_in),
    .port_rd(rd_b)
  );

  // boot strap sampled from line 6 of the first instance
  gpp_strap u_strap (
    .pclk(pclk),
    .presetn(presetn),
    .pin_level(pa_in[`GPP_BOOT_LINE]),
    .boot_mode_select(boot_mode_select),
    .captured(boot_capt)
  );

endmodule
